// file: irq_mask_defs.svh
// Register offsets, field positions and reset values of the interrupt mask
`ifndef IRQ_MASK_DEFS_SVH
`define IRQ_MASK_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define IRQ_OFS_MASK      32'hFFB0_0030
`define IRQ_OFS_SET       32'hFFB0_0034
`define IRQ_OFS_CLEAR     32'hFFB0_0038
`define IRQ_OFS_EVT_STAT  32'hFFB0_003C
`define IRQ_OFS_EVT_MASK  32'hFFB0_0040

// ----------------------------------------------------------------------
// Field positions of the source layout
// ----------------------------------------------------------------------
`define IRQ_DMA_MSB       31
`define IRQ_DMA_LSB       22
`define IRQ_HOST_MSB      21
`define IRQ_ETH_RX_BIT    17
`define IRQ_ETH_TX_BIT    16
`define IRQ_SER_A_RX_BIT  15
`define IRQ_SER_A_TX_BIT  14
`define IRQ_SER_B_RX_BIT  13
`define IRQ_SER_B_TX_BIT  12
`define IRQ_WDOG_BIT      6
`define IRQ_TMR1_BIT      5
`define IRQ_TMR2_BIT      4
`define IRQ_EDGE_MSB      3
`define IRQ_LIVE_BITS     32'hFFFF_F07F

// ----------------------------------------------------------------------
// Event status bits and reset values
// ----------------------------------------------------------------------
`define EVT_IRQ_RISE_BIT  0
`define EVT_BUS_ERR_BIT   1
`define EVT_W             2
`define IRQ_MASK_RESET    32'h0000_0000

`endif

// file: irq_mask_pkg.sv
// Types shared by the interrupt mask logic
package irq_mask_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_e;

endpackage

// file: irq_mask_set_clear.sv
// Interrupt mask with set and clear ports behind an AXI4-Lite slave
//
// Contract
// [R01] A write of ones to the set port sets those mask bits, zeros keep.
// [R02] A write of ones to the clear port clears those mask bits, zeros keep.
// [R03] DMA channels one to ten sit on bits 31 down to 22, channel one high.
// [R04] Host-interface ports one to four sit on bits 21 down to 18.
// [R05] Ethernet receive is bit 17 and Ethernet transmit is bit 16.
// [R06] Serial A receive/transmit are bits 15/14, serial B bits 13/12.
// [R07] The watchdog condition sits on bit 6.
// [R08] Timer one sits on bit 5 and timer two on bit 4.
// [R09] Edge detectors of pins three to zero sit on bits 3 down to 0.
// [R10] Enabled status is raw status AND the mask.
// [R11] The OR of all enabled status bits drives the normal interrupt line.
// [R12] A read at the set port address returns the enabled status.
// [R13] A read at the clear port address returns the raw status.
// [R14] Bits 11 down to 7 ignore writes and read as zero.
`timescale 1ns/10ps
`include "irq_mask_defs.svh"

module irq_mask_set_clear (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // AXI4-Lite write
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Interrupt sources
  input wire logic [9:0] dma_irq_in,
  input wire logic host_if_port_one_irq_in,
  input wire logic host_if_port_two_irq_in,
  input wire logic host_if_port_three_irq_in,
  input wire logic host_if_port_four_irq_in,
  input wire logic eth_receive_irq_in,
  input wire logic eth_transmit_irq_in,
  input wire logic serial_a_receive_irq_in,
  input wire logic serial_a_transmit_irq_in,
  input wire logic serial_b_receive_irq_in,
  input wire logic serial_b_transmit_irq_in,
  input wire logic watchdog_irq_in,
  input wire logic timer_one_irq_in,
  input wire logic timer_two_irq_in,
  input wire logic edge_pin0_irq_in,
  input wire logic edge_pin1_irq_in,
  input wire logic edge_pin2_irq_in,
  input wire logic edge_pin3_irq_in,
  // Interrupt outputs
  output logic irq_out,
  output logic evt_irq_out
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  irq_mask_pkg::word_t mask_r, mask_nxt, raw_r, raw_nxt;
  irq_mask_pkg::word_t addr_r, addr_nxt, data_r, data_nxt;
  irq_mask_pkg::word_t rdata_r, rdata_nxt, lane_bits, wr_bits, rd_word;
  logic [3:0] strb_r, strb_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt, irq_r, irq_nxt, evt_irq_r, evt_irq_nxt;
  logic wr_fire, rd_fire, wr_hit, rd_hit;
  irq_mask_pkg::axi_resp_e bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [`EVT_W-1:0] evt_stat_r, evt_stat_nxt, evt_mask_r, evt_mask_nxt;
  logic [`EVT_W-1:0] evt_set, evt_clr;

  // --------------------------------------------------------------------
  // Byte lanes
  // --------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_bits[8*g +: 8] = {8{strb_r[g]}};
  end
  assign wr_bits = data_r & lane_bits & `IRQ_LIVE_BITS; // [R14]

  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_fire = s_axi_arvalid_in && arready_r;
  assign wr_hit = (addr_r == `IRQ_OFS_MASK) || (addr_r == `IRQ_OFS_SET) ||
                  (addr_r == `IRQ_OFS_CLEAR) ||
                  (addr_r == `IRQ_OFS_EVT_STAT) ||
                  (addr_r == `IRQ_OFS_EVT_MASK);

  // --------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr_in)
      `IRQ_OFS_MASK: rd_word = mask_r;
      `IRQ_OFS_SET: rd_word = raw_r & mask_r; // [R10] [R12]
      `IRQ_OFS_CLEAR: rd_word = raw_r; // [R13]
      `IRQ_OFS_EVT_STAT: rd_word = 32'(evt_stat_r);
      `IRQ_OFS_EVT_MASK: rd_word = 32'(evt_mask_r);
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    addr_nxt = addr_r;
    w_hold_nxt = w_hold_r;
    data_nxt = data_r;
    strb_nxt = strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_awvalid_in && awready_r) begin
      aw_hold_nxt = 1'b1;
      addr_nxt = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_r) begin
      w_hold_nxt = 1'b1;
      data_nxt = s_axi_wdata_in;
      strb_nxt = s_axi_wstrb_in;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? irq_mask_pkg::RESP_OKAY : irq_mask_pkg::RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = rd_hit ? irq_mask_pkg::RESP_OKAY : irq_mask_pkg::RESP_SLVERR;
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_hold_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      w_hold_r <= 1'b0;
      data_r <= 32'h0000_0000;
      strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= irq_mask_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= irq_mask_pkg::RESP_OKAY;
    end else if (ce_in) begin
      aw_hold_r <= aw_hold_nxt;
      addr_r <= addr_nxt;
      w_hold_r <= w_hold_nxt;
      data_r <= data_nxt;
      strb_r <= strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Source map, mask and interrupt line
  // --------------------------------------------------------------------
  always_comb begin
    raw_nxt = 32'h0000_0000;
    for (int i = 0; i < 10; i++) begin
      raw_nxt[`IRQ_DMA_MSB - i] = dma_irq_in[i]; // [R03]
    end
    raw_nxt[`IRQ_HOST_MSB -: 4] = {host_if_port_one_irq_in,
                                   host_if_port_two_irq_in,
                                   host_if_port_three_irq_in,
                                   host_if_port_four_irq_in}; // [R04]
    raw_nxt[`IRQ_ETH_RX_BIT] = eth_receive_irq_in; // [R05]
    raw_nxt[`IRQ_ETH_TX_BIT] = eth_transmit_irq_in; // [R05]
    raw_nxt[`IRQ_SER_A_RX_BIT] = serial_a_receive_irq_in; // [R06]
    raw_nxt[`IRQ_SER_A_TX_BIT] = serial_a_transmit_irq_in; // [R06]
    raw_nxt[`IRQ_SER_B_RX_BIT] = serial_b_receive_irq_in; // [R06]
    raw_nxt[`IRQ_SER_B_TX_BIT] = serial_b_transmit_irq_in; // [R06]
    raw_nxt[`IRQ_WDOG_BIT] = watchdog_irq_in; // [R07]
    raw_nxt[`IRQ_TMR1_BIT] = timer_one_irq_in; // [R08]
    raw_nxt[`IRQ_TMR2_BIT] = timer_two_irq_in; // [R08]
    raw_nxt[`IRQ_EDGE_MSB -: 4] = {edge_pin3_irq_in, edge_pin2_irq_in,
                                   edge_pin1_irq_in,
                                   edge_pin0_irq_in}; // [R09]
    mask_nxt = mask_r;
    if (wr_fire) begin
      case (addr_r)
        `IRQ_OFS_MASK: mask_nxt = (mask_r & ~lane_bits) | wr_bits;
        `IRQ_OFS_SET: mask_nxt = mask_r | wr_bits; // [R01]
        `IRQ_OFS_CLEAR: mask_nxt = mask_r & ~wr_bits; // [R02]
        default: mask_nxt = mask_r;
      endcase
    end
    mask_nxt = mask_nxt & `IRQ_LIVE_BITS; // [R14]
    irq_nxt = |(raw_nxt & mask_nxt); // [R10] [R11]
  end

  // --------------------------------------------------------------------
  // Event status
  // --------------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[`EVT_IRQ_RISE_BIT] = irq_nxt && !irq_r;
    evt_set[`EVT_BUS_ERR_BIT] = (wr_fire && !wr_hit) || (rd_fire && !rd_hit);
    evt_clr = '0;
    evt_mask_nxt = evt_mask_r;
    if (wr_fire && addr_r == `IRQ_OFS_EVT_STAT) begin
      evt_clr = wr_bits[`EVT_W-1:0];
    end
    if (wr_fire && addr_r == `IRQ_OFS_EVT_MASK) begin
      evt_mask_nxt = (evt_mask_r & ~lane_bits[`EVT_W-1:0]) |
                     wr_bits[`EVT_W-1:0];
    end
    evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;
    evt_irq_nxt = |(evt_stat_nxt & evt_mask_nxt);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      raw_r <= 32'h0000_0000;
      mask_r <= `IRQ_MASK_RESET;
      irq_r <= 1'b0;
      evt_stat_r <= '0;
      evt_mask_r <= '0;
      evt_irq_r <= 1'b0;
    end else if (ce_in) begin
      raw_r <= raw_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_mask_r <= evt_mask_nxt;
      evt_irq_r <= evt_irq_nxt;
    end
  end

  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out = wready_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign irq_out = irq_r;
  assign evt_irq_out = evt_irq_r;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_wr_to(logic [31:0] a);
    ce_in && wr_fire && addr_r == a;
  endsequence

  a_set_port: assert property (s_wr_to(`IRQ_OFS_SET) |=> // [R01]
    ((mask_r & $past(wr_bits)) == $past(wr_bits)) &&
    ((mask_r & ~$past(wr_bits)) == ($past(mask_r) & ~$past(wr_bits))))
    else $error("set port write did not set mask bits");
  a_clear_port: assert property (s_wr_to(`IRQ_OFS_CLEAR) |=> // [R02]
    ((mask_r & $past(wr_bits)) == 32'h0000_0000) &&
    ((mask_r & ~$past(wr_bits)) == ($past(mask_r) & ~$past(wr_bits))))
    else $error("clear port write did not clear mask bits");
  a_dma_map: assert property (ce_in |=> // [R03]
    raw_r[31] == $past(dma_irq_in[0]) && raw_r[22] == $past(dma_irq_in[9]))
    else $error("dma channel on wrong bit");
  a_host_map: assert property (ce_in |=> // [R04]
    raw_r[21] == $past(host_if_port_one_irq_in) &&
    raw_r[18] == $past(host_if_port_four_irq_in))
    else $error("host port on wrong bit");
  a_eth_map: assert property (ce_in |=> // [R05]
    raw_r[17] == $past(eth_receive_irq_in) &&
    raw_r[16] == $past(eth_transmit_irq_in))
    else $error("ethernet on wrong bit");
  a_serial_map: assert property (ce_in |=> // [R06]
    raw_r[15] == $past(serial_a_receive_irq_in) &&
    raw_r[12] == $past(serial_b_transmit_irq_in))
    else $error("serial on wrong bit");
  a_wdog_map: assert property (ce_in |=> // [R07]
    raw_r[6] == $past(watchdog_irq_in))
    else $error("watchdog on wrong bit");
  a_timer_map: assert property (ce_in |=> // [R08]
    raw_r[5] == $past(timer_one_irq_in) &&
    raw_r[4] == $past(timer_two_irq_in))
    else $error("timer on wrong bit");
  a_edge_map: assert property (ce_in |=> // [R09]
    raw_r[3] == $past(edge_pin3_irq_in) && raw_r[0] == $past(edge_pin0_irq_in))
    else $error("edge pin on wrong bit");
  a_irq_line: assert property (irq_out == |(raw_r & mask_r)) // [R11]
    else $error("interrupt line differs from enabled status");
  a_enabled_read: assert property (rd_fire && ce_in && // [R10] [R12]
    s_axi_araddr_in == `IRQ_OFS_SET |=>
    s_axi_rvalid_out && s_axi_rdata_out == ($past(raw_r) & $past(mask_r)))
    else $error("enabled status read wrong");
  a_raw_read: assert property (rd_fire && ce_in && // [R13]
    s_axi_araddr_in == `IRQ_OFS_CLEAR |=>
    s_axi_rvalid_out && s_axi_rdata_out == $past(raw_r))
    else $error("raw status read wrong");
  a_unused_zero: assert property (mask_r[11:7] == 5'h00 && // [R14]
    raw_r[11:7] == 5'h00)
    else $error("unused bits not zero");

endmodule // irq_mask_set_clear

// file: irq_src_model.sv
// Model of the interrupt sources feeding the mask block
`timescale 1ns/10ps

module irq_src_model (
  // Request pattern in register layout
  input wire logic [31:0] pattern_in,
  // DMA and host interface requests
  output logic [9:0] dma_out,
  output logic host_one_out,
  output logic host_two_out,
  output logic host_three_out,
  output logic host_four_out,
  // Ethernet and serial requests
  output logic eth_rx_out,
  output logic eth_tx_out,
  output logic ser_a_rx_out,
  output logic ser_a_tx_out,
  output logic ser_b_rx_out,
  output logic ser_b_tx_out,
  // Watchdog, timers and edge detectors
  output logic wdog_out,
  output logic tmr_one_out,
  output logic tmr_two_out,
  output logic [3:0] edge_out
);
  // --------------------------------------------------------------------
  // Layout bit to source port
  // --------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      dma_out[i] = pattern_in[31 - i];
    end
    host_one_out = pattern_in[21];
    host_two_out = pattern_in[20];
    host_three_out = pattern_in[19];
    host_four_out = pattern_in[18];
    eth_rx_out = pattern_in[17];
    eth_tx_out = pattern_in[16];
    ser_a_rx_out = pattern_in[15];
    ser_a_tx_out = pattern_in[14];
    ser_b_rx_out = pattern_in[13];
    ser_b_tx_out = pattern_in[12];
    wdog_out = pattern_in[6];
    tmr_one_out = pattern_in[5];
    tmr_two_out = pattern_in[4];
    edge_out = pattern_in[3:0];
  end
endmodule // irq_src_model

// file: tb_irq_mask_set_clear.sv
// Self-checking testbench of the interrupt mask block
`timescale 1ns/10ps
`include "irq_mask_defs.svh"

module tb_irq_mask_set_clear;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [31:0] s_axi_awaddr_in = '0, s_axi_wdata_in = '0;
  logic [31:0] s_axi_araddr_in = '0, src_pattern = '0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, irq_out, evt_irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
  logic [31:0] s_axi_rdata_out, rd;
  logic [9:0] dma_irq_in;
  logic [3:0] edge_irq;
  logic host_if_port_one_irq_in, host_if_port_two_irq_in;
  logic host_if_port_three_irq_in, host_if_port_four_irq_in;
  logic eth_receive_irq_in, eth_transmit_irq_in, watchdog_irq_in;
  logic serial_a_receive_irq_in, serial_a_transmit_irq_in;
  logic serial_b_receive_irq_in, serial_b_transmit_irq_in;
  logic timer_one_irq_in, timer_two_irq_in;
  int err_count = 0;
  int n_checks = 0;
  localparam logic [31:0] LIVE = `IRQ_LIVE_BITS;

  always #25 sys_clk_in = ~sys_clk_in;

  irq_src_model irq_src_model_inst (.pattern_in(src_pattern),
    .dma_out(dma_irq_in), .host_one_out(host_if_port_one_irq_in),
    .host_two_out(host_if_port_two_irq_in),
    .host_three_out(host_if_port_three_irq_in),
    .host_four_out(host_if_port_four_irq_in),
    .eth_rx_out(eth_receive_irq_in), .eth_tx_out(eth_transmit_irq_in),
    .ser_a_rx_out(serial_a_receive_irq_in),
    .ser_a_tx_out(serial_a_transmit_irq_in),
    .ser_b_rx_out(serial_b_receive_irq_in),
    .ser_b_tx_out(serial_b_transmit_irq_in), .wdog_out(watchdog_irq_in),
    .tmr_one_out(timer_one_irq_in), .tmr_two_out(timer_two_irq_in),
    .edge_out(edge_irq));

  irq_mask_set_clear irq_mask_set_clear_inst (.sys_clk_in, .rst_in, .ce_in,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
    .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .dma_irq_in, .host_if_port_one_irq_in,
    .host_if_port_two_irq_in, .host_if_port_three_irq_in,
    .host_if_port_four_irq_in, .eth_receive_irq_in, .eth_transmit_irq_in,
    .serial_a_receive_irq_in, .serial_a_transmit_irq_in,
    .serial_b_receive_irq_in, .serial_b_transmit_irq_in, .watchdog_irq_in,
    .timer_one_irq_in, .timer_two_irq_in, .edge_pin0_irq_in(edge_irq[0]),
    .edge_pin1_irq_in(edge_irq[1]), .edge_pin2_irq_in(edge_irq[2]),
    .edge_pin3_irq_in(edge_irq[3]), .irq_out, .evt_irq_out);

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic check(input irq_mask_pkg::word_t seen, exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [31:0] addr, data);
    logic aw_hit, w_hit, b_hit;
    int n;
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= addr;
    s_axi_wdata_in <= data;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      aw_hit = s_axi_awvalid_in && s_axi_awready_out === 1'b1;
      w_hit = s_axi_wvalid_in && s_axi_wready_out === 1'b1;
      b_hit = s_axi_bvalid_out === 1'b1;
      resp = s_axi_bresp_out;
      @(posedge sys_clk_in);
      if (aw_hit) s_axi_awvalid_in <= 1'b0;
      if (w_hit) s_axi_wvalid_in <= 1'b0;
      n++;
    end while (!b_hit && n < 100);
    s_axi_bready_in <= 1'b0;
    check(b_hit, 1'b1, "write answer");
  endtask

  task automatic axi_read(input logic [31:0] addr);
    logic ar_hit, r_hit;
    int n;
    @(posedge sys_clk_in);
    s_axi_araddr_in <= addr;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      ar_hit = s_axi_arvalid_in && s_axi_arready_out === 1'b1;
      r_hit = s_axi_rvalid_out === 1'b1;
      rd = s_axi_rdata_out;
      resp = s_axi_rresp_out;
      @(posedge sys_clk_in);
      if (ar_hit) s_axi_arvalid_in <= 1'b0;
      n++;
    end while (!r_hit && n < 100);
    s_axi_rready_in <= 1'b0;
    check(r_hit, 1'b1, "read answer");
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic source_map();
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk_in);
      src_pattern <= 32'h0000_0001 << i;
      settle();
      axi_read(`IRQ_OFS_CLEAR);
      check(rd, (32'h0000_0001 << i) & LIVE, "raw bit");
    end
    @(posedge sys_clk_in);
    src_pattern <= '0;
  endtask

  task automatic set_clear_ports();
    axi_read(`IRQ_OFS_MASK);
    check(rd, `IRQ_MASK_RESET, "mask reset");
    check(resp, irq_mask_pkg::RESP_OKAY, "mapped read");
    axi_write(`IRQ_OFS_SET, 32'hFFFF_FFFF);
    check(resp, irq_mask_pkg::RESP_OKAY, "mapped write");
    axi_read(`IRQ_OFS_MASK);
    check(rd, LIVE, "set all");
    axi_write(`IRQ_OFS_CLEAR, 32'h5A5A_0F0F);
    axi_read(`IRQ_OFS_MASK);
    check(rd, LIVE & ~32'h5A5A_0F0F, "clear some");
    axi_write(`IRQ_OFS_SET, 32'h0000_0003);
    axi_read(`IRQ_OFS_MASK);
    check(rd, LIVE & 32'hA5A5_F0F3, "set keeps");
    s_axi_wstrb_in <= 4'h1;
    axi_write(`IRQ_OFS_CLEAR, 32'hFFFF_FFFF);
    s_axi_wstrb_in <= 4'hF;
    axi_read(`IRQ_OFS_MASK);
    check(rd, 32'hA5A5_F000, "clear lane zero");
    axi_write(`IRQ_OFS_CLEAR, 32'hFFFF_FFFF);
    axi_read(`IRQ_OFS_MASK);
    check(rd, 32'h0000_0000, "clear all");
  endtask

  task automatic enabled_irq();
    axi_write(`IRQ_OFS_SET, 32'h8001_0040);
    @(posedge sys_clk_in);
    src_pattern <= 32'h4001_2010;
    settle();
    check(irq_out, 1'b1, "irq on");
    axi_read(`IRQ_OFS_SET);
    check(rd, 32'h0001_0000, "enabled status");
    axi_read(`IRQ_OFS_CLEAR);
    check(rd, 32'h4001_2010, "raw status");
    axi_write(`IRQ_OFS_CLEAR, 32'h0001_0000);
    settle();
    check(irq_out, 1'b0, "irq off");
    axi_read(`IRQ_OFS_SET);
    check(rd, 32'h0000_0000, "enabled none");
  endtask

  task automatic event_line();
    axi_write(`IRQ_OFS_EVT_MASK, 32'h0000_0001);
    settle();
    check(evt_irq_out, 1'b1, "event line on");
    axi_write(`IRQ_OFS_EVT_STAT, 32'h0000_0003);
    settle();
    check(evt_irq_out, 1'b0, "event line off");
    axi_write(32'hFFB0_0050, 32'hFFFF_FFFF);
    check(resp, irq_mask_pkg::RESP_SLVERR, "unmapped write");
    axi_read(32'hFFB0_0050);
    check(resp, irq_mask_pkg::RESP_SLVERR, "unmapped read");
    check(rd, 32'h0000_0000, "unmapped data");
    axi_write(`IRQ_OFS_EVT_MASK, 32'h0000_0002);
    settle();
    check(evt_irq_out, 1'b1, "bus error event");
  endtask

  task automatic clock_enable();
    @(posedge sys_clk_in);
    ce_in <= 1'b0;
    src_pattern <= 32'h8000_0000;
    settle();
    check(irq_out, 1'b0, "frozen while disabled");
    @(posedge sys_clk_in);
    ce_in <= 1'b1;
    settle();
    check(irq_out, 1'b1, "irq after enable");
    @(posedge sys_clk_in);
    src_pattern <= '0;
  endtask

  initial begin
    #2_000_000;
    err_count++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    set_clear_ports();
    source_map();
    enabled_irq();
    event_line();
    clock_enable();
    summarize();
  end
endmodule // tb_irq_mask_set_clear
